// *** rtl/ubg_defs.svh ***
/*
 * Constants of the baudrate generator and autobaud detector: field widths,
 * divide factors, reload values, mode codes and detection characters.
 * Assumes inclusion by bare name from rtl/ and a single clock domain.
 */
// Operation
// R1: Fractional prescale gives n/512 of module clock
// R2: Reload value is unsigned 13-bit, up to 8191
// R3: Sync mode timer output is four times baudrate
// R4: Sync baud is clock/8 or clock/12 per reload
// R5: Detector finds format and one of nine rates
// R6: Detector only matches its nine fixed rates
// R7: Detector times frames with prescaler ticks only
// R8: Success writes mode and reload, receive ready
// R9: Software sets prescaler and run before enable
// R10: Only "at" or "AT" pairs are accepted
// R11: Five frame formats accepted and identified
// R12: Prescaler preset; reload loaded on detection
// R13: Detection works with fixed /2 or /3 prescale
// R14: Software sets prescaler output to 11.0592 MHz
// R15: Slots 0-4: factors 48..576, reloads 2..35
// R16: Slots 5-8: factors 1152..9216, reloads 71..575
// R17: Success writes mode code and odd-parity bit
// R18: Fraction zero means divide ratio one
// R19: Timer counts down, pulses and reloads on underflow
// R20: Failed attempt leaves mode and reload untouched
`ifndef UBG_DEFS_SVH
`define UBG_DEFS_SVH

`define UBG_RX_BITS       9
`define UBG_ASYNC_DIV     4'hF
`define UBG_SYNC_DIV      4'h3
`define UBG_FIX2_LAST     2'h1
`define UBG_FIX3_LAST     2'h2
`define UBG_GAP_BITS      5'h10
`define UBG_DF0  18'h00030
`define UBG_DF1  18'h00060
`define UBG_DF2  18'h000C0
`define UBG_DF3  18'h00120
`define UBG_DF4  18'h00240
`define UBG_DF5  18'h00480
`define UBG_DF6  18'h00900
`define UBG_DF7  18'h01200
`define UBG_DF8  18'h02400

`define UBG_MODE_7P      3'h3
`define UBG_MODE_8P      3'h7
`define UBG_MODE_8N      3'h1
`define UBG_MODE_RESET   3'h0
`define UBG_RELOAD_RESET 13'h0000

`define UBG_CHR_A_LO 8'h61
`define UBG_CHR_T_LO 8'h74
`define UBG_CHR_A_UP 8'h41
`define UBG_CHR_T_UP 8'h54

`endif

// *** rtl/ubg_pkg.sv ***
/*
 * Types shared by the baudrate generator modules.
 * Assumes ubg_defs.svh is available on the include path.
 */
package ubg_pkg;

    // Detector states
    typedef enum logic [3:0] {
        UBG_D_OFF   = 4'h0,
        UBG_D_IDLE  = 4'h1,
        UBG_D_HUNT  = 4'h2,
        UBG_D_START = 4'h3,
        UBG_D_BITS1 = 4'h4,
        UBG_D_GAP   = 4'h5,
        UBG_D_BITS2 = 4'h6,
        UBG_D_CHECK = 4'h7,
        UBG_D_DONE  = 4'h8
    } ubg_dstate_t;

    // Detected frame formats
    typedef enum logic [2:0] {
        UBG_F_7E = 3'h0,
        UBG_F_7O = 3'h1,
        UBG_F_8E = 3'h2,
        UBG_F_8O = 3'h3,
        UBG_F_8N = 3'h4
    } ubg_fmt_t;

endpackage : ubg_pkg

// *** rtl/ubg_pre_if.sv ***
/*
 * Interface between the generator core and its input prescaler.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

interface ubg_pre_if;
    logic       frac_sel;
    logic       fixed_sel;
    logic       sync_mode;
    logic       run;
    logic [8:0] fraction;
    logic       div_tick;

    modport pre  (input frac_sel, fixed_sel, sync_mode, run, fraction,
                  output div_tick);
    modport core (output frac_sel, fixed_sel, sync_mode, run, fraction,
                  input div_tick);
endinterface : ubg_pre_if

`default_nettype wire

// *** rtl/ubg_prescale.sv ***
/*
 * Input prescaler: fractional n/512 divider or fixed /2, /3 divider,
 * giving one div_tick pulse per prescaler output period.
 * Assumes an asynchronous active-low reset from the parent.
 */
`timescale 1ns/10ps
`default_nettype none

`include "ubg_defs.svh"

module ubg_prescale
    import ubg_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Link to the core
    ubg_pre_if.pre    pre
);

    logic [8:0] acc;
    logic [8:0] next_acc;
    logic [1:0] fix;
    logic [1:0] next_fix;
    logic       tick;
    logic       next_tick;

    // -------
    // Divider next state
    // -------
    always_comb
    begin
        logic [9:0] sum;
        logic [1:0] last;
        sum       = {1'b0, acc} + {1'b0, pre.fraction};
        last      = pre.fixed_sel ? `UBG_FIX3_LAST : `UBG_FIX2_LAST;
        next_acc  = acc;
        next_fix  = fix;
        next_tick = 1'b0;
        if (!pre.run)
        begin
            next_acc = 9'h000;
            next_fix = 2'h0;
        end
        else if (pre.frac_sel && !pre.sync_mode)
        begin
            // Zero fraction passes every clock, else carry out
            if (pre.fraction == 9'h000)        // see R18
                next_tick = 1'b1;
            else
            begin
                next_acc  = sum[8:0];          // see R1
                next_tick = sum[9];
            end
        end
        else
        begin
            // Fixed /2 or /3, always so in synchronous mode
            next_tick = (fix == last);         // see R13
            next_fix  = (fix == last) ? 2'h0 : fix + 2'h1;
        end
    end

    // Divider registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc  <= 9'h000;
            fix  <= 2'h0;
            tick <= 1'b0;
        end
        else
        begin
            acc  <= next_acc;
            fix  <= next_fix;
            tick <= next_tick;
        end
    end

    assign pre.div_tick = tick;

endmodule : ubg_prescale

`default_nettype wire

// *** rtl/ubg_top.sv ***
/*
 * Baudrate generator with autobaud detection.
 * Assumes configuration ports are driven on clk; rxd is asynchronous.
 */
`timescale 1ns/10ps
`default_nettype none

`include "ubg_defs.svh"

module ubg_top
    import ubg_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Prescaler configuration
    input  wire logic        fractional_prescale_select,
    input  wire logic        fixed_prescale_select,
    input  wire logic [8:0]  fraction_value,
    input  wire logic        baud_run_bit,
    input  wire logic        sync_mode,
    // Software writes of reload and mode
    input  wire logic        reload_wr,
    input  wire logic [12:0] reload_wdata,
    input  wire logic        mode_wr,
    input  wire logic [2:0]  mode_wdata,
    input  wire logic        parity_wdata,
    // Detection control and serial input
    input  wire logic        detect_enable_bit,
    input  wire logic        rxd,
    // Generator outputs
    output logic [12:0]      baud_reload_value,
    output logic [12:0]      baud_timer_value,
    output logic             sample_tick,
    output logic             bit_rate_tick,
    // Detection results
    output logic [2:0]       frame_format_field,
    output logic             parity_polarity_bit,
    output logic [3:0]       rate_slot,
    output logic             detect_busy,
    output logic             detect_done
);

    // -------
    // Reset release and receive pin synchroniser
    // -------
    logic rst_m;
    logic rst_n;
    logic rx_m;
    logic rx;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_m <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_m <= 1'b1;
            rst_n <= rst_m;
        end
    end

    // Two stages before any logic sees the pin
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_m <= 1'b1;
            rx   <= 1'b1;
        end
        else
        begin
            rx_m <= rxd;
            rx   <= rx_m;
        end
    end

    // -------
    // Prescaler
    // -------
    ubg_pre_if pre_if ();

    assign pre_if.frac_sel  = fractional_prescale_select;
    assign pre_if.fixed_sel = fixed_prescale_select;
    assign pre_if.sync_mode = sync_mode;
    assign pre_if.run       = baud_run_bit;
    assign pre_if.fraction  = fraction_value;

    ubg_prescale u_pre (
        .clk   (clk),
        .rst_n (rst_n),
        .pre   (pre_if.pre)
    );

    wire logic div_tick = pre_if.div_tick;

    // -------
    // Lookup functions
    // -------
    function automatic logic [17:0] df_of(input logic [3:0] s);
        case (s)
            4'h0:    df_of = `UBG_DF0;
            4'h1:    df_of = `UBG_DF1;
            4'h2:    df_of = `UBG_DF2;
            4'h3:    df_of = `UBG_DF3;
            4'h4:    df_of = `UBG_DF4;
            4'h5:    df_of = `UBG_DF5;
            4'h6:    df_of = `UBG_DF6;
            4'h7:    df_of = `UBG_DF7;
            default: df_of = `UBG_DF8;
        endcase
    endfunction : df_of

    // Reload is a sixteenth of the factor, less one
    function automatic logic [12:0] rl_of(input logic [3:0] s);
        logic [17:0] d;
        d     = df_of(s);
        rl_of = d[16:4] - 13'h0001;            // see R15 see R16
    endfunction : rl_of

    // Nearest of nine slots; 4'hF when the width fits none
    function automatic logic [3:0] slot_of(input logic [17:0] w);
        logic [3:0]  s;
        logic [17:0] hi;
        s = 4'hF;
        if (w >= (`UBG_DF0 >> 1))              // see R6
        begin
            for (int i = 8; i >= 0; i--)
            begin
                if (i == 8)
                    hi = `UBG_DF8 + (`UBG_DF8 >> 1);
                else
                    hi = (df_of(4'(i)) + df_of(4'(i + 1))) >> 1;
                if (w < hi)
                    s = 4'(i);
            end
        end
        slot_of = s;
    endfunction : slot_of

    // Expected nine bits after the start bit, first bit in bit 0
    function automatic logic [8:0] expect9(input ubg_fmt_t f,
                                           input logic [7:0] c);
        case (f)
            UBG_F_7E: expect9 = {1'b1, ^c[6:0], c[6:0]};
            UBG_F_7O: expect9 = {1'b1, ~^c[6:0], c[6:0]};
            UBG_F_8E: expect9 = {^c, c};
            UBG_F_8O: expect9 = {~^c, c};
            default:  expect9 = {1'b1, c};
        endcase
    endfunction : expect9

    // -------
    // Autobaud detector
    // -------
    ubg_dstate_t st;
    ubg_dstate_t next_st;
    logic [17:0] cnt;
    logic [17:0] next_cnt;
    logic [17:0] wait_n;
    logic [17:0] next_wait_n;
    logic [3:0]  nbit;
    logic [3:0]  next_nbit;
    logic [3:0]  slot;
    logic [3:0]  next_slot;
    logic [8:0]  sr1;
    logic [8:0]  next_sr1;
    logic [8:0]  sr2;
    logic [8:0]  next_sr2;
    logic        seen_hi;
    logic        next_seen_hi;
    logic        hit;
    logic        next_hit;
    logic [2:0]  hit_mode;
    logic [2:0]  next_hit_mode;
    logic        hit_odd;
    logic        next_hit_odd;
    logic        next_busy;

    // Detector next state, timed by prescaler ticks alone
    always_comb
    begin
        logic [3:0] s;
        logic       lo_ok;
        logic       up_ok;
        next_st       = st;
        next_cnt      = cnt;
        next_wait_n   = wait_n;
        next_nbit     = nbit;
        next_slot     = slot;
        next_sr1      = sr1;
        next_sr2      = sr2;
        next_seen_hi  = seen_hi;
        next_hit      = 1'b0;
        next_hit_mode = `UBG_MODE_8N;
        next_hit_odd  = 1'b0;
        s             = slot_of(cnt);
        lo_ok         = 1'b0;
        up_ok         = 1'b0;
        case (st)
            UBG_D_OFF:
                if (detect_enable_bit)         // see R9
                    next_st = UBG_D_IDLE;
            UBG_D_IDLE:
                if (rx)
                    next_st = UBG_D_HUNT;
            UBG_D_HUNT:
                if (!rx)
                begin
                    next_cnt = 18'h00000;
                    next_st  = UBG_D_START;
                end
            UBG_D_START:
            begin
                // Start bit width gives the rate; bit 0 is high
                if (div_tick)                  // see R7
                    next_cnt = cnt + 18'h00001;
                if (rx)
                begin
                    next_slot   = s;           // see R5
                    next_cnt    = 18'h00000;
                    next_wait_n = df_of(s) >> 1;
                    next_nbit   = 4'h0;
                    next_st     = (s == 4'hF) ? UBG_D_IDLE
                                              : UBG_D_BITS1;  // see R20
                end
                else if (cnt > `UBG_DF8 + (`UBG_DF8 >> 1))
                    next_st = UBG_D_IDLE;      // see R20
            end
            UBG_D_BITS1,
            UBG_D_BITS2:
            begin
                // Sample each bit at its middle
                if (div_tick)
                    next_cnt = cnt + 18'h00001;
                if (div_tick && (cnt + 18'h00001 >= wait_n))
                begin
                    next_cnt    = 18'h00000;
                    next_wait_n = df_of(slot);
                    next_nbit   = nbit + 4'h1;
                    if (st == UBG_D_BITS1)
                        next_sr1 = {rx, sr1[8:1]};
                    else
                        next_sr2 = {rx, sr2[8:1]};
                    if (nbit == 4'(`UBG_RX_BITS - 1))
                    begin
                        next_seen_hi = 1'b0;
                        next_st = (st == UBG_D_BITS1) ? UBG_D_GAP
                                                      : UBG_D_CHECK;
                    end
                end
            end
            UBG_D_GAP:
            begin
                // Stop bit, then start of the second character
                if (div_tick)
                    next_cnt = cnt + 18'h00001;
                if (rx)
                    next_seen_hi = 1'b1;
                if (seen_hi && !rx)
                begin
                    next_cnt    = 18'h00000;
                    next_wait_n = df_of(slot) + (df_of(slot) >> 1);
                    next_nbit   = 4'h0;
                    next_st     = UBG_D_BITS2;
                end
                else if (cnt >= df_of(slot) * `UBG_GAP_BITS)
                    next_st = UBG_D_IDLE;      // see R20
            end
            UBG_D_CHECK:
            begin
                // Lowest-numbered matching format wins; pairs must share case
                next_st = UBG_D_IDLE;          // see R20
                for (int f = 4; f >= 0; f--)
                begin
                    lo_ok = (sr1 == expect9(ubg_fmt_t'(f), `UBG_CHR_A_LO))
                         && (sr2 == expect9(ubg_fmt_t'(f), `UBG_CHR_T_LO));
                    up_ok = (sr1 == expect9(ubg_fmt_t'(f), `UBG_CHR_A_UP))
                         && (sr2 == expect9(ubg_fmt_t'(f), `UBG_CHR_T_UP));
                    if (lo_ok || up_ok)        // see R10 see R11
                    begin
                        next_hit      = 1'b1;
                        next_st       = UBG_D_DONE;
                        next_hit_mode = (f < 2) ? `UBG_MODE_7P  // see R17
                                      : (f < 4) ? `UBG_MODE_8P
                                                : `UBG_MODE_8N;
                        next_hit_odd  = (f == 1) || (f == 3);
                    end
                end
            end
            UBG_D_DONE:
                ;
            default:
                next_st = UBG_D_OFF;
        endcase
        if (!detect_enable_bit)
            next_st = UBG_D_OFF;
        next_busy = (next_st != UBG_D_OFF) && (next_st != UBG_D_DONE);
    end

    // Detector registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st          <= UBG_D_OFF;
            cnt         <= 18'h00000;
            wait_n      <= 18'h00000;
            nbit        <= 4'h0;
            slot        <= 4'h0;
            sr1         <= 9'h000;
            sr2         <= 9'h000;
            seen_hi     <= 1'b0;
            hit         <= 1'b0;
            hit_mode    <= `UBG_MODE_8N;
            hit_odd     <= 1'b0;
            detect_busy <= 1'b0;
        end
        else
        begin
            st          <= next_st;
            cnt         <= next_cnt;
            wait_n      <= next_wait_n;
            nbit        <= next_nbit;
            slot        <= next_slot;
            sr1         <= next_sr1;
            sr2         <= next_sr2;
            seen_hi     <= next_seen_hi;
            hit         <= next_hit;
            hit_mode    <= next_hit_mode;
            hit_odd     <= next_hit_odd;
            detect_busy <= next_busy;
        end
    end

    // -------
    // Reload, mode and baud timer
    // -------
    logic [12:0] next_reload;
    logic [12:0] next_timer;
    logic [2:0]  next_mode;
    logic        next_odd;
    logic [3:0]  next_rslot;
    logic [3:0]  bdiv;
    logic [3:0]  next_bdiv;
    logic        next_sample;
    logic        next_bit;
    logic        next_done;

    // Generator next state
    always_comb
    begin
        logic [3:0] last;
        last        = sync_mode ? `UBG_SYNC_DIV : `UBG_ASYNC_DIV;
        next_reload = baud_reload_value;
        next_mode   = frame_format_field;
        next_odd    = parity_polarity_bit;
        next_rslot  = rate_slot;
        next_done   = 1'b0;
        next_timer  = baud_timer_value;
        next_bdiv   = bdiv;
        next_sample = 1'b0;
        next_bit    = 1'b0;
        if (reload_wr)
            next_reload = reload_wdata;        // see R2
        if (mode_wr)
        begin
            next_mode = mode_wdata;
            next_odd  = parity_wdata;
        end
        // Detection result overrides a same-cycle software write
        if (hit)                               // see R8 see R12
        begin
            next_reload = rl_of(slot);
            next_mode   = hit_mode;            // see R17
            next_odd    = hit_odd;
            next_rslot  = slot;
            next_done   = 1'b1;
        end
        if (!baud_run_bit)
        begin
            // Stopped: timer follows reload, loads on restart
            next_timer = next_reload;
            next_bdiv  = 4'h0;
        end
        else if (reload_wr || hit)
            next_timer = next_reload;
        else if (div_tick)
        begin
            if (baud_timer_value == 13'h0000)  // see R19
            begin
                next_timer  = baud_reload_value;
                next_sample = 1'b1;
                next_bdiv   = (bdiv >= last) ? 4'h0 : bdiv + 4'h1;
                next_bit    = (bdiv >= last);  // see R3 see R4
            end
            else
                next_timer = baud_timer_value - 13'h0001;
        end
    end

    // Generator registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            baud_reload_value   <= `UBG_RELOAD_RESET;
            baud_timer_value    <= `UBG_RELOAD_RESET;
            frame_format_field  <= `UBG_MODE_RESET;
            parity_polarity_bit <= 1'b0;
            rate_slot           <= 4'h0;
            bdiv                <= 4'h0;
            sample_tick         <= 1'b0;
            bit_rate_tick       <= 1'b0;
            detect_done         <= 1'b0;
        end
        else
        begin
            baud_reload_value   <= next_reload;
            baud_timer_value    <= next_timer;
            frame_format_field  <= next_mode;
            parity_polarity_bit <= next_odd;
            rate_slot           <= next_rslot;
            bdiv                <= next_bdiv;
            sample_tick         <= next_sample;
            bit_rate_tick       <= next_bit;
            detect_done         <= next_done;
        end
    end

endmodule : ubg_top

`default_nettype wire

// *** dv/ubg_top_sva.sv ***
/* Port checker for ubg_top.
   Bound into every ubg_top; sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
module ubg_top_sva
(
    // Clock, reset and inputs
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        baud_run_bit,
    input wire logic        sync_mode,
    input wire logic        reload_wr,
    input wire logic [12:0] reload_wdata,
    input wire logic        mode_wr,
    input wire logic [2:0]  mode_wdata,
    input wire logic        parity_wdata,
    // Outputs watched
    input wire logic [12:0] baud_reload_value,
    input wire logic [12:0] baud_timer_value,
    input wire logic        sample_tick,
    input wire logic        bit_rate_tick,
    input wire logic [2:0]  frame_format_field,
    input wire logic        parity_polarity_bit,
    input wire logic [3:0]  rate_slot,
    input wire logic        detect_done
);
    localparam logic [12:0] RL [9] = '{13'h002, 13'h005, 13'h00B, 13'h011,
        13'h023, 13'h047, 13'h08F, 13'h11F, 13'h23F};
    logic [4:0] n;
    logic       ok;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Underflows since the last bit tick
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n || !baud_run_bit)
            {n, ok} <= 6'h00;
        else if (bit_rate_tick)
            {n, ok} <= 6'h01;
        else
            n <= n + {4'h0, sample_tick};
    end
    AST_RELOAD_WR: assert property (reload_wr |=> detect_done ||
        baud_reload_value == $past(reload_wdata)) else $error("reload write");
    AST_MODE_WR: assert property (mode_wr |=> detect_done ||
        {frame_format_field, parity_polarity_bit} ==
        $past({mode_wdata, parity_wdata})) else $error("mode write");
    AST_DONE_RL: assert property (detect_done |->
        rate_slot < 4'h9 && baud_reload_value == RL[rate_slot])
        else $error("reload after detect");
    AST_DONE_MODE: assert property (detect_done |->
        frame_format_field inside {3'h3, 3'h7, 3'h1} &&
        !(frame_format_field == 3'h1 && parity_polarity_bit))
        else $error("mode after detect");
    AST_HOLD: assert property (!detect_done && !$past(reload_wr) &&
        !$past(mode_wr) |-> $stable({baud_reload_value, frame_format_field,
        parity_polarity_bit})) else $error("result changed");
    AST_TICK_RL: assert property (sample_tick &&
        $stable(baud_reload_value) |-> baud_timer_value == baud_reload_value)
        else $error("no reload on underflow");
    AST_STOPPED: assert property (!baud_run_bit [*3] |-> !sample_tick &&
        baud_timer_value == baud_reload_value) else $error("stopped timer");
    AST_BIT_RATE: assert property (bit_rate_tick && ok |->
        n + {4'h0, sample_tick} == (sync_mode ? 5'h04 : 5'h10))
        else $error("bit tick ratio");
endmodule : ubg_top_sva
bind ubg_top ubg_top_sva ubg_top_sva_i (.*);
`default_nettype wire

// *** dv/ubg_remote_tx.sv ***
/* Remote sender of a two-character frame.
   Assumes go pulses one cycle and words stay steady meanwhile. */
`timescale 1ns/10ps
`default_nettype none
module ubg_remote_tx
(
    // Clock and control
    input  wire logic        clk,
    input  wire logic        go,
    input  wire logic [17:0] words,
    input  wire logic [15:0] bit_len,
    // Serial line
    output var logic         rxd,
    output var logic         busy
);
    // Start, nine bits LSB first, two stop times per character
    initial
    begin
        rxd = 1'b1;
        busy = 1'b0;
        forever
        begin
            @(posedge clk iff go);
            busy = 1'b1;
            for (int c = 0; c < 2; c++)
                for (int b = 0; b < 12; b++)
                begin
                    @(negedge clk);
                    rxd = b == 0 ? 1'b0 : b > 9 ? 1'b1 : words[c*9+b-1];
                    repeat (bit_len - 1) @(negedge clk);
                end
            busy = 1'b0;
        end
    end
endmodule : ubg_remote_tx
`default_nettype wire

// *** dv/tb_top.sv ***
/* Self-checking bench for ubg_top with a remote sender.
   Assumes a 50 MHz clock and no other masters. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    typedef struct packed
    {
        logic [17:0] w;
        logic        fx;
        logic [3:0]  s;
        logic [2:0]  m;
        logic        o;
    } ubg_row_t;
    localparam ubg_row_t ROWS [6] = '{
        '{{9'h174, 9'h1E1}, 1'b0, 4'h0, 3'h3, 1'b0},
        '{{9'h154, 9'h1C1}, 1'b0, 4'h1, 3'h3, 1'b1},
        '{{9'h074, 9'h161}, 1'b0, 4'h2, 3'h7, 1'b0},
        '{{9'h054, 9'h141}, 1'b0, 4'h3, 3'h7, 1'b1},
        '{{9'h174, 9'h161}, 1'b0, 4'h5, 3'h1, 1'b0},
        '{{9'h174, 9'h1E1}, 1'b1, 4'h0, 3'h3, 1'b0}};
    localparam logic [12:0] RLT [6] = '{13'h002, 13'h005, 13'h00B, 13'h011,
        13'h023, 13'h047};
    localparam logic [15:0] DF [6] = '{16'h0030, 16'h0060, 16'h00C0,
        16'h0120, 16'h0240, 16'h0480};
    logic        clk, arst_n, frac, fixd, run, sync, rwr, mwr, den, go;
    logic        rxd, tx_busy, st, bt, pp, busy, done;
    logic [8:0]  fr;
    logic [12:0] rwd, rl, tv;
    logic [2:0]  ff;
    logic [3:0]  slot;
    logic [17:0] words;
    logic [15:0] blen;
    int          miscompares, tests_run, cyc, k;
    ubg_top ubg_top_i (.clk(clk), .arst_n(arst_n),
        .fractional_prescale_select(frac), .fixed_prescale_select(fixd),
        .fraction_value(fr), .baud_run_bit(run), .sync_mode(sync),
        .reload_wr(rwr), .reload_wdata(rwd), .mode_wr(mwr),
        .mode_wdata(3'h7), .parity_wdata(1'b1), .detect_enable_bit(den),
        .rxd(rxd), .baud_reload_value(rl), .baud_timer_value(tv),
        .sample_tick(st), .bit_rate_tick(bt), .frame_format_field(ff),
        .parity_polarity_bit(pp), .rate_slot(slot), .detect_busy(busy),
        .detect_done(done));
    ubg_remote_tx ubg_remote_tx_i (.clk(clk), .go(go), .words(words),
        .bit_len(blen), .rxd(rxd), .busy(tx_busy));
    task report_and_stop;
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [12:0] e, v, input string nm);
        tests_run++;
        if (v !== e)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, v);
        end
    endtask : chk
    // Rearm detection and send one frame
    task automatic send(input logic [17:0] w, input logic [15:0] b);
        den = 1'b0;
        repeat (3) @(negedge clk);
        {den, words, blen, go} = {1'b1, w, b, 1'b1};
        @(negedge clk) go = 1'b0;
    endtask : send
    // Bit tick period after a stopped reconfiguration
    task automatic per(input logic s, f, q, input logic [8:0] n,
        input logic [12:0] e);
        int c;
        run = 1'b0;
        repeat (3) @(negedge clk);
        {sync, fixd, frac, fr, run} = {s, f, q, n, 1'b1};
        for (int i = 0; i < 3; i++)
            for (c = 0; c < 2000 && (c == 0 || bt !== 1'b1); c++)
                @(negedge clk);
        chk(e, c[12:0], "period");
    endtask : per
    // Clock and run limit
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            miscompares++;
            report_and_stop();
        end
    end
    // Main sequence
    initial
    begin
        {arst_n, frac, fixd, run, sync, rwr, mwr, den, go} = 9'h000;
        {fr, rwd, words, blen} = '0;
        repeat (8) @(negedge clk);
        arst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk(13'h0000, rl, "reset reload");
        chk(13'h0000, {10'h000, ff}, "reset mode");
        {frac, run} = 2'h3;
        foreach (ROWS[r])
        begin
            frac = !ROWS[r].fx;
            send(ROWS[r].w, DF[ROWS[r].s] << ROWS[r].fx);
            for (k = 0; k < 30000 && done !== 1'b1; k++) @(negedge clk);
            chk(13'h0001, {12'h000, done}, "done");
            chk(RLT[ROWS[r].s], rl, "reload");
            chk({10'h000, ROWS[r].m}, {10'h000, ff}, "mode");
            chk({12'h000, ROWS[r].o}, {12'h000, pp}, "odd");
            chk({9'h000, ROWS[r].s}, {9'h000, slot}, "slot");
            while (tx_busy) @(negedge clk);
        end
        frac = 1'b1;
        send({9'h1D4, 9'h1E1}, DF[0]);
        for (k = 0; tx_busy; k += done) @(negedge clk);
        chk(13'h0000, k[12:0], "mixed done");
        chk(RLT[0], rl, "kept reload");
        {den, rwr, mwr, rwd} = {3'h3, 13'h1FFF};
        @(negedge clk) rwr = 1'b0;
        chk(13'h1FFF, rl, "reload max");
        chk(13'h000F, {9'h000, ff, pp}, "mode write");
        {rwr, mwr, rwd} = {2'h2, 13'h0002};
        @(negedge clk) rwr = 1'b0;
        den = 1'b0;
        per(1'b0, 1'b0, 1'b1, 9'h000, 13'h0030);
        per(1'b0, 1'b0, 1'b1, 9'h100, 13'h0060);
        per(1'b1, 1'b0, 1'b0, 9'h000, 13'h0018);
        per(1'b1, 1'b1, 1'b0, 9'h000, 13'h0024);
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
